// ---- iarr_pkg.sv ----
// Purpose: constants and types for the remote alias remap block
// Assumes: byte-wide register port, two receive ports
// Notes: offsets are byte addresses on the local register port
package iarr_pkg;
    localparam int unsigned IARR_NUM_PORTS = 2;
    localparam int unsigned IARR_NUM_PERIPH = 3;
    localparam int unsigned IARR_PORT_W = 1;
    localparam logic [7:0] IARR_PORT_SEL_OFFSET = 8'h4c;
    localparam logic [7:0] IARR_ALIAS_OFFSET = 8'h5c;
    localparam logic [7:0] IARR_PERIPH0_OFFSET = 8'h5d;
    localparam logic [7:0] IARR_PERIPH1_OFFSET = 8'h5e;
    localparam logic [7:0] IARR_PERIPH2_OFFSET = 8'h5f;
    localparam int unsigned IARR_ADDR_MSB = 7;
    localparam int unsigned IARR_ADDR_LSB = 1;
    localparam int unsigned IARR_AUTO_ACK_BIT = 0;
    localparam logic [7:0] IARR_ALIAS_RESET = 8'h00;
    localparam logic [7:0] IARR_PERIPH_RESET = 8'h00;
    localparam logic [7:0] IARR_PORT_SEL_RESET = 8'h00;
    localparam logic [6:0] IARR_ALIAS_OFF = 7'h00;
    // per-peripheral alias addresses live outside this block
    typedef logic [6:0] iarr_addr_t;
endpackage : iarr_pkg

// ---- iarr_regs_if.sv ----
// Purpose: carrier between remap core and register memory
// Assumes: single clock
// Notes: one write port, one registered read port
`timescale 1ns/10ps
interface iarr_regs_if;
    logic wr_en;
    logic [iarr_pkg::IARR_PORT_W-1:0] wr_port;
    logic [1:0] wr_idx;
    logic [7:0] wr_data;
    logic [iarr_pkg::IARR_PORT_W-1:0] rd_port;
    logic [1:0] rd_idx;
    logic [7:0] rd_data;
    logic [7:0] cfg [iarr_pkg::IARR_NUM_PORTS][4];
    modport core (output wr_en, wr_port, wr_idx, wr_data, rd_port, rd_idx,
        input rd_data, cfg);
    modport mem (input wr_en, wr_port, wr_idx, wr_data, rd_port, rd_idx,
        output rd_data, cfg);
endinterface : iarr_regs_if

// ---- iarr_port_regs.sv ----
// Purpose: per-receive-port copies of alias and peripheral registers
// Assumes: index 0 is the bridge alias, 1..3 peripheral entries
// Notes: read data comes from a register
`timescale 1ns/10ps
module iarr_port_regs (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // core side
    iarr_regs_if.mem regs
);
    import iarr_pkg::*;

    logic [7:0] mem_q [IARR_NUM_PORTS][4];

    // ---------------------------------------------------------------
    // storage
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            for (int p = 0; p < IARR_NUM_PORTS; p++) begin
                mem_q[p][0] <= IARR_ALIAS_RESET;
                for (int i = 1; i < 4; i++) begin
                    mem_q[p][i] <= IARR_PERIPH_RESET;
                end
            end
        end else if (regs.wr_en) begin
            if (regs.wr_idx == 2'h0) begin
                mem_q[regs.wr_port][0] <= regs.wr_data;
            end else begin
                // reserved low bit held at zero
                mem_q[regs.wr_port][regs.wr_idx] <= {regs.wr_data[7:1], 1'b0};
            end
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            regs.rd_data <= 8'h00;
        end else begin
            regs.rd_data <= mem_q[regs.rd_port][regs.rd_idx];
        end
    end

    assign regs.cfg = mem_q;
endmodule : iarr_port_regs

// ---- iarr_remap.sv ----
// Purpose: alias decode and address remap toward the control channel
// Assumes: local I2C front end presents one address byte per request
// Notes: remapped address goes out registered, one cycle after request
`timescale 1ns/10ps

// Behaviour
// - bridge alias sits in bits 7:1; matching addresses head remote
// - bridge alias match rewrites address to the peripheral entry address
// - zero alias disables all remote decode through it
// - auto-acknowledge bit 0 acks every remote write when set
// - each peripheral entry holds 7-bit physical address in bits 7:1
// - peripheral alias n remaps to entry n, then crosses control channel
// - registers exist per receive port; port select 0x4c chooses copy
module iarr_remap (
    // clock and reset
    input wire logic clock,
    input wire logic resetn,
    // local register port
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    // local i2c address decode request
    input wire logic req_valid,
    input wire logic [iarr_pkg::IARR_PORT_W-1:0] req_port,
    input wire logic [6:0] req_addr,
    input wire logic req_write,
    // aliases of peripheral entries, from outside registers
    input wire logic [6:0] periph_alias_0,
    input wire logic [6:0] periph_alias_1,
    input wire logic [6:0] periph_alias_2,
    // toward side control channel
    output logic fwd_valid,
    output logic [6:0] fwd_addr,
    output logic [iarr_pkg::IARR_PORT_W-1:0] fwd_port,
    output logic fwd_auto_ack,
    output logic fwd_miss
);
    import iarr_pkg::*;

    iarr_regs_if regs ();
    logic [7:0] port_sel;
    logic rd_pending;
    logic rd_local;
    logic [1:0] next_idx;
    logic idx_hit;
    logic [7:0] sel_shadow;
    logic sel_read;
    logic [7:0] alias_reg;
    logic bridge_hit;
    logic hit;
    logic [6:0] next_addr;

    iarr_port_regs u_regs (
        .clock(clock),
        .resetn(resetn),
        .regs(regs)
    );

    // ---------------------------------------------------------------
    // register decode
    // ---------------------------------------------------------------
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        unique case (a)
            IARR_ALIAS_OFFSET: reg_index = 3'b100;
            IARR_PERIPH0_OFFSET: reg_index = 3'b101;
            IARR_PERIPH1_OFFSET: reg_index = 3'b110;
            IARR_PERIPH2_OFFSET: reg_index = 3'b111;
            default: reg_index = 3'b000;
        endcase
    endfunction : reg_index

    // physical address field of an entry; bit 0 is reserved
    function automatic iarr_addr_t phys_field(input logic [7:0] r);
        phys_field = r[IARR_ADDR_MSB:IARR_ADDR_LSB];
    endfunction : phys_field

    always_comb begin
        {idx_hit, next_idx} = reg_index(reg_addr);
    end

    // ---------------------------------------------------------------
    // port select
    // ---------------------------------------------------------------
    // only the low bit steers, the full byte reads back

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            port_sel <= IARR_PORT_SEL_RESET;
        end else if (reg_wr && reg_addr == IARR_PORT_SEL_OFFSET) begin
            port_sel <= reg_wdata;
        end
    end

    // port select picks which copy the register port reaches
    assign regs.wr_en = reg_wr && idx_hit;
    assign regs.wr_port = port_sel[IARR_PORT_W-1:0];
    assign regs.wr_idx = next_idx;
    // entries keep bit 0 clear so it always reads back as zero
    assign regs.wr_data = (next_idx == 2'h0) ? reg_wdata :
        {phys_field(reg_wdata), 1'b0};
    assign regs.rd_port = port_sel[IARR_PORT_W-1:0];
    assign regs.rd_idx = next_idx;

    // ---------------------------------------------------------------
    // read path: two cycles from strobe to data
    // ---------------------------------------------------------------
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_pending <= 1'b0;
        end else begin
            rd_pending <= reg_rd;
        end
    end

    // marks a read that the register memory answers
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rd_local <= 1'b0;
        end else begin
            rd_local <= reg_rd && idx_hit;
        end
    end

    // unmapped reads return zero; port select reads back through its shadow copy
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rvalid <= 1'b0;
        end else begin
            reg_rvalid <= rd_pending;
        end
    end

    // port select copy taken with the read, answered next cycle
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sel_shadow <= 8'h00;
            sel_read <= 1'b0;
        end else begin
            sel_shadow <= port_sel;
            sel_read <= reg_rd && reg_addr == IARR_PORT_SEL_OFFSET;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            reg_rdata <= 8'h00;
        end else if (rd_local) begin
            reg_rdata <= regs.rd_data;
        end else if (sel_read) begin
            reg_rdata <= sel_shadow;
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // ---------------------------------------------------------------
    // alias match and remap
    // ---------------------------------------------------------------
    always_comb begin
        alias_reg = regs.cfg[req_port][0];
        // zero alias never matches
        bridge_hit = phys_field(alias_reg) != IARR_ALIAS_OFF &&
            req_addr == phys_field(alias_reg);
    end

    // bridge alias wins over a peripheral alias of the same value
    always_comb begin
        hit = 1'b1;
        next_addr = req_addr;
        if (bridge_hit) begin
            // bridge alias takes entry 0's physical address
            next_addr = phys_field(regs.cfg[req_port][1]);
        end else if (req_addr == periph_alias_0) begin
            next_addr = phys_field(regs.cfg[req_port][1]);
        end else if (req_addr == periph_alias_1) begin
            next_addr = phys_field(regs.cfg[req_port][2]);
        end else if (req_addr == periph_alias_2) begin
            next_addr = phys_field(regs.cfg[req_port][3]);
        end else begin
            hit = 1'b0;
        end
    end

    // ---------------------------------------------------------------
    // forward outputs
    // ---------------------------------------------------------------
    // exactly one of valid or miss pulses for each request
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fwd_valid <= 1'b0;
            fwd_miss <= 1'b0;
        end else begin
            fwd_valid <= req_valid && hit;
            fwd_miss <= req_valid && !hit;
        end
    end

    // address and port hold until the next request
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fwd_addr <= 7'h00;
            fwd_port <= '0;
        end else if (req_valid) begin
            fwd_addr <= next_addr;
            fwd_port <= req_port;
        end
    end

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            fwd_auto_ack <= 1'b0;
        end else if (req_valid) begin
            // ack regardless of link lock or remote answer
            fwd_auto_ack <= hit && req_write &&
                alias_reg[IARR_AUTO_ACK_BIT];
        end
    end
endmodule : iarr_remap

// ---- iarr_far_model.sv ----
// Purpose: far-end stand-in counting frames sent on the control channel
// Assumes: one forwarded address per fwd_valid pulse
// Notes: accepts every frame, since this path has no back-pressure
`timescale 1ns/10ps
module iarr_far_model (
    // control channel side
    input wire logic clock,
    input wire logic fwd_valid,
    // observation
    output int n_frames
);
    initial n_frames = 0;
    always @(posedge clock) begin
        if (fwd_valid === 1'b1) n_frames++;
    end
endmodule : iarr_far_model

// ---- iarr_remap_properties.sv ----
// Purpose: port-level properties of the alias remap block
// Assumes: single clock domain
// Notes: shadows only bridge alias and entry 0, enough for the hit path
`timescale 1ns/10ps
module iarr_remap_properties (
    // clock, reset, register port
    input wire logic clock,
    input wire logic resetn,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_rvalid,
    input wire logic [7:0] reg_rdata,
    // decode request and forward side
    input wire logic req_valid,
    input wire logic [iarr_pkg::IARR_PORT_W-1:0] req_port,
    input wire logic [6:0] req_addr,
    input wire logic req_write,
    input wire logic fwd_valid,
    input wire logic [6:0] fwd_addr,
    input wire logic [iarr_pkg::IARR_PORT_W-1:0] fwd_port,
    input wire logic fwd_auto_ack,
    input wire logic fwd_miss
);
    import iarr_pkg::*;

    logic [IARR_PORT_W-1:0] sel;
    logic [7:0] al_q [IARR_NUM_PORTS];
    logic [7:0] e0_q [IARR_NUM_PORTS];
    logic hit;
    default clocking cb @(posedge clock); endclocking
    default disable iff (!resetn);
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            sel <= '0;
            al_q <= '{default: 8'h00};
            e0_q <= '{default: 8'h00};
        end else if (reg_wr) begin
            if (reg_addr == IARR_PORT_SEL_OFFSET) sel <= reg_wdata[0];
            if (reg_addr == IARR_ALIAS_OFFSET) al_q[sel] <= reg_wdata;
            if (reg_addr == IARR_PERIPH0_OFFSET) e0_q[sel] <= reg_wdata;
        end
    end
    // zero alias never decodes
    assign hit = req_valid && al_q[req_port][7:1] != 7'h00
        && req_addr == al_q[req_port][7:1];
    a_one_answer: assert property (req_valid |=> fwd_valid != fwd_miss)
        else $error("request gave no single answer");
    a_no_spurious: assert property
        (!req_valid |=> !fwd_valid && !fwd_miss)
        else $error("answer without request");
    a_port_follow: assert property
        (req_valid |=> fwd_port == $past(req_port))
        else $error("forward port differs from request port");
    a_hold_addr: assert property
        (!req_valid |=> $stable(fwd_addr) && $stable(fwd_port))
        else $error("forward fields moved without request");
    a_read_latency: assert property (reg_rd |-> ##2 reg_rvalid)
        else $error("read answer late");
    a_read_cause: assert property (reg_rvalid |-> $past(reg_rd, 2))
        else $error("read answer without read");
    a_reserved_zero: assert property
        (reg_rd && reg_addr >= IARR_PERIPH0_OFFSET &&
        reg_addr <= IARR_PERIPH2_OFFSET |-> ##2 !reg_rdata[0])
        else $error("reserved entry bit read as one");
    a_bridge_remap: assert property
        (hit |=> fwd_valid && fwd_addr == $past(e0_q[req_port][7:1]))
        else $error("bridge alias not remapped to entry 0");
    a_auto_ack: assert property
        (hit |=> fwd_auto_ack == $past(req_write && al_q[req_port][0]))
        else $error("auto acknowledge wrong");
    c_hit: cover property (hit ##1 fwd_valid);
    c_miss: cover property (req_valid ##1 fwd_miss);
    c_read: cover property (reg_rd ##2 reg_rvalid);
endmodule : iarr_remap_properties
bind iarr_remap iarr_remap_properties u_props (
    .clock(clock),
    .resetn(resetn),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_rvalid(reg_rvalid),
    .reg_rdata(reg_rdata),
    .req_valid(req_valid),
    .req_port(req_port),
    .req_addr(req_addr),
    .req_write(req_write),
    .fwd_valid(fwd_valid),
    .fwd_addr(fwd_addr),
    .fwd_port(fwd_port),
    .fwd_auto_ack(fwd_auto_ack),
    .fwd_miss(fwd_miss)
);

// ---- i2c_remote_alias_remap_bench.sv ----
// Purpose: self-checking bench for the alias remap block
// Assumes: two ports, peripheral aliases fixed on the side inputs
// Notes: drivers note expectations in queues, a watcher matches them
`timescale 1ns/10ps
module i2c_remote_alias_remap_bench;
    import iarr_pkg::*;
    logic clock = 0, resetn = 0, reg_wr = 0, reg_rd = 0, req_valid = 0;
    logic req_write = 1, reg_rvalid, fwd_valid, fwd_miss, fwd_auto_ack;
    logic [IARR_PORT_W-1:0] req_port = '0, fwd_port;
    logic [7:0] reg_addr = '0, reg_wdata = '0, reg_rdata;
    logic [6:0] req_addr = '0, fwd_addr, al, ph [3];
    logic [6:0] periph_alias_0 = 7'h10, periph_alias_1 = 7'h11;
    logic [6:0] periph_alias_2 = 7'h12;
    logic [7:0] qr [$];
    logic [8:0] qf [$];
    int n_fail = 0, num_checks = 0, n_frames;
    always #4 clock = ~clock;
    iarr_remap uut (
        .clock(clock),
        .resetn(resetn),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid),
        .req_valid(req_valid),
        .req_port(req_port),
        .req_addr(req_addr),
        .req_write(req_write),
        .periph_alias_0(periph_alias_0),
        .periph_alias_1(periph_alias_1),
        .periph_alias_2(periph_alias_2),
        .fwd_valid(fwd_valid),
        .fwd_addr(fwd_addr),
        .fwd_port(fwd_port),
        .fwd_auto_ack(fwd_auto_ack),
        .fwd_miss(fwd_miss)
    );
    iarr_far_model far (.clock(clock), .fwd_valid(fwd_valid),
        .n_frames(n_frames));
    task automatic note(string what, logic [8:0] e, logic [8:0] s);
        num_checks++;
        if (e !== s) begin
            n_fail++;
            $display("wrong value %s expected %h seen %h", what, e, s);
        end
    endtask : note
    task automatic chk_rd(logic [7:0] e);
        note("read data", {1'b0, e}, {1'b0, reg_rdata});
    endtask : chk_rd
    task automatic chk_fw(logic [8:0] e);
        logic [7:0] seen;
        seen = fwd_miss ? 8'h00 : {fwd_addr, fwd_auto_ack};
        note("forward", e, {fwd_miss, seen});
    endtask : chk_fw
    always @(negedge clock) begin
        if (reg_rvalid === 1'b1)
            chk_rd(qr.size() ? qr.pop_front() : 'x);
        if (fwd_valid === 1'b1 || fwd_miss === 1'b1)
            chk_fw(qf.size() ? qf.pop_front() : 'x);
    end
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge clock);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask : wr
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge clock);
        reg_rd <= 1'b1;
        reg_addr <= a;
        qr.push_back(e);
        @(posedge clock);
        reg_rd <= 1'b0;
    endtask : rd
    task automatic rq(int p, logic [6:0] a, logic [8:0] e);
        @(posedge clock);
        req_valid <= 1'b1;
        req_port <= p[IARR_PORT_W-1:0];
        req_addr <= a;
        qf.push_back(e);
        @(posedge clock);
        req_valid <= 1'b0;
    endtask : rq
    task automatic final_report();
        $display("checks %0d mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : final_report
    initial begin
        void'($urandom(1162));
        repeat (8) @(posedge clock);
        resetn <= 1;
        for (int i = 0; i < 4; i++)
            rd(IARR_ALIAS_OFFSET + 8'(i), 8'h00);
        rd(8'h70, 8'h00);
        $display("test reset values done");
        al = 7'h20 | 7'($urandom() & 32'h1f);
        wr(IARR_ALIAS_OFFSET, {al, 1'b1});
        rd(IARR_ALIAS_OFFSET, {al, 1'b1});
        for (int i = 0; i < 3; i++) begin
            ph[i] = 7'($urandom());
            wr(IARR_PERIPH0_OFFSET + 8'(i), {ph[i], 1'b1});
            rd(IARR_PERIPH0_OFFSET + 8'(i), {ph[i], 1'b0});
        end
        $display("test register access done");
        rq(0, al, {1'b0, ph[0], 1'b1});
        req_write <= 1'b0;
        rq(0, al, {1'b0, ph[0], 1'b0});
        req_write <= 1'b1;
        for (int i = 0; i < 3; i++)
            rq(0, 7'h10 + 7'(i), {1'b0, ph[i], 1'b1});
        rq(0, 7'h05, 9'h100);
        $display("test port 0 decode done");
        wr(IARR_PORT_SEL_OFFSET, 8'h01);
        rd(IARR_PORT_SEL_OFFSET, 8'h01);
        rd(IARR_ALIAS_OFFSET, 8'h00);
        rd(IARR_PERIPH0_OFFSET, 8'h00);
        rq(1, 7'h00, 9'h100);
        rq(1, al, 9'h100);
        rq(1, 7'h11, 9'h000);
        wr(IARR_PORT_SEL_OFFSET, 8'h00);
        wr(IARR_ALIAS_OFFSET, 8'h01);
        rq(0, al, 9'h100);
        $display("test port 1 and zero alias done");
        for (int k = 0; k < 20 && qr.size() + qf.size() > 0; k++)
            @(posedge clock);
        if (qr.size() + qf.size() > 0) n_fail++;
        note("frames", 9'd6, 9'(n_frames));
        final_report();
    end
endmodule : i2c_remote_alias_remap_bench
